/* verilog/fcsd_decoder.sv */
// flash command sequence decoder: watches processor bus cycles to the
// flash region and turns unlock sequences into operation launches.
// assumes one-cycle write/read strobes on CLK; engine reports done.
`timescale 1ns/1ps
`include "fcsd_params.svh"
module fcsd_decoder
   import fcsd_pkg::*;
#(
   parameter int          ADDR_W   = 32,        // bus address width
   parameter logic [15:0] CODE_MFR = 16'h0011,  // arbitrary value
   parameter logic [15:0] CODE_DEV = 16'h0022,  // arbitrary value
   parameter logic [15:0] CODE_MAC = 16'h0033   // arbitrary value
) (
   // clock and reset
   input  wire logic              CLK,
   input  wire logic              RST_N,
   // processor bus cycle
   input  wire logic              BUS_WR,
   input  wire logic              BUS_RD,
   input  wire logic [ADDR_W-1:0] BUS_ADDR,
   input  wire logic [31:0]       BUS_WDATA,
   // engine status and configuration
   input  wire logic              OP_DONE,
   input  wire logic              SECURE,
   // launch toward the flash engine
   output logic                   OP_START,
   output logic [3:0]             OP_CODE,
   output logic                   OP_ERASE_ARRAY,
   output logic [18:0]            TARGET_ADDR,
   output logic [7:0]             LOCK_BIT_SELECT,
   output logic                   LOCK_IN_HIGH_WORD,
   output logic [3:0]             SWAP_BIT_SELECT,
   // program words
   output logic                   PROGRAM_WORD_VALID,
   output logic [31:0]            PROGRAM_WORD,
   // identification read answer
   output logic                   CODE_VALID,
   output logic [15:0]            CODE_VALUE,
   // decoder status
   output logic                   BUSY,
   output logic                   ID_MODE
);
   initial begin
      if (ADDR_W != 32) $error("fcsd_decoder: address must be 32 bits");
   end

   // address fields of the current cycle
   logic       in_region;    // upper bits hit flash region
   logic       pat_54;       // pattern 0x54 in bits 15:9
   logic       pat_aa;       // pattern 0xaa in bits 15:9
   logic [7:0] cmd;          // command byte
   logic [7:0] sel_field;    // bits 11:4 selector
   assign in_region = BUS_ADDR[31:20] == `FCSD_REGION;        // [R4]
   assign pat_54    = BUS_ADDR[15:9] == `FCSD_PAT_54;         // [R5]
   assign pat_aa    = BUS_ADDR[15:9] == `FCSD_PAT_AA;         // [R5]
   assign cmd       = BUS_WDATA[7:0];                         // [R2]
   assign sel_field = BUS_ADDR[11:4];
   // a write of f0 with bit 19 low returns to read mode, except while an operation runs
   logic wr_hit;
   logic is_reset;
   assign wr_hit   = BUS_WR && in_region;                     // [R1]
   assign is_reset = wr_hit && cmd == `FCSD_D_RESET
                     && !BUS_ADDR[19];                        // [R7]

   // sequence state
   fcsd_state_t st_q, st_d;       // decoder step
   logic [7:0]  cmd3_q, cmd3_d;   // third-cycle command byte
   logic [2:0]  wcnt_q, wcnt_d;   // program words captured
   logic [1:0]  csel_q, csel_d;   // identification code select
   logic        csv_q, csv_d;     // code select is valid
   logic        launch;           // operation accepted this cycle
   fcsd_op_t    op_sel;           // operation to launch
   logic [18:0] tgt_sel;          // captured target

   // next state of the sequence walker
   always_comb begin
      st_d    = st_q;
      cmd3_d  = cmd3_q;
      wcnt_d  = wcnt_q;
      csel_d  = csel_q;
      csv_d   = csv_q;
      launch  = 1'b0;
      op_sel  = FCSD_OP_NONE;
      tgt_sel = '0;
      case (st_q)
         // running operation: every sequence is ignored
         FCSD_BUSY: begin
            if (OP_DONE) st_d = FCSD_READ;                    // [R21]
         end
         // first unlock cycle
         FCSD_READ: begin
            if (wr_hit && !is_reset) begin
               if (pat_54 && cmd == `FCSD_D_AA) st_d = FCSD_U2; // [R6]
            end
         end
         // second unlock cycle
         FCSD_U2: begin
            if (is_reset) begin
               st_d = FCSD_READ;                              // [R23]
            end else if (wr_hit) begin
               if (pat_aa && cmd == `FCSD_D_55) st_d = FCSD_U3; // [R6]
               else st_d = FCSD_READ;                         // [R25]
            end
         end
         // third cycle carries the command byte
         FCSD_U3: begin
            if (is_reset) begin
               st_d = FCSD_READ;                              // [R23]
            end else if (wr_hit) begin
               cmd3_d = cmd;
               st_d   = FCSD_READ;                            // [R25]
               if (pat_54) begin
                  case (cmd)
                     `FCSD_D_PROG: begin
                        st_d   = FCSD_PROG;                   // [R8]
                        wcnt_d = '0;
                     end
                     `FCSD_D_ERASE: st_d = FCSD_E4;           // [R10]
                     `FCSD_D_LOCKP: st_d = FCSD_LOCK4;        // [R14]
                     `FCSD_D_LOCKE: st_d = FCSD_LOCK4;        // [R16]
                     `FCSD_D_ID:    st_d = FCSD_ID;           // [R18]
                     default:       st_d = FCSD_READ;         // [R25]
                  endcase
               end
            end
         end
         // fourth erase unlock
         FCSD_E4: begin
            if (is_reset) begin
               st_d = FCSD_READ;                              // [R23]
            end else if (wr_hit) begin
               if (pat_54 && cmd == `FCSD_D_AA) st_d = FCSD_E5; // [R10]
               else st_d = FCSD_READ;                         // [R25]
            end
         end
         // fifth erase unlock
         FCSD_E5: begin
            if (is_reset) begin
               st_d = FCSD_READ;                              // [R23]
            end else if (wr_hit) begin
               if (pat_aa && cmd == `FCSD_D_55) st_d = FCSD_E6; // [R10]
               else st_d = FCSD_READ;                         // [R25]
            end
         end
         // sixth cycle picks the erase type and target
         FCSD_E6: begin
            if (is_reset) begin
               st_d = FCSD_READ;                              // [R23]
            end else if (wr_hit) begin
               st_d   = FCSD_BUSY;
               launch = 1'b1;
               case (cmd)
                  `FCSD_D_CHIP: op_sel = FCSD_OP_CHIP;        // [R10]
                  `FCSD_D_AREA: begin
                     op_sel  = FCSD_OP_AREA;                  // [R11]
                     tgt_sel = BUS_ADDR[18:0];
                  end
                  `FCSD_D_BLOCK: begin
                     op_sel  = FCSD_OP_BLOCK;
                     tgt_sel = {BUS_ADDR[18:13], 13'h0000};   // [R11]
                  end
                  `FCSD_D_PAGE: begin
                     op_sel  = FCSD_OP_PAGE;
                     tgt_sel = {BUS_ADDR[18:12], 12'h000};    // [R12]
                  end
                  default: begin
                     launch = 1'b0;
                     st_d   = FCSD_READ;                      // [R25]
                  end
               endcase
            end
         end
         // fourth cycle of lock program, lock erase or swap set
         FCSD_LOCK4: begin
            if (is_reset) begin
               st_d = FCSD_READ;                              // [R23]
            end else if (wr_hit) begin
               st_d = FCSD_READ;                              // [R25]
               if (cmd3_q == `FCSD_D_LOCKE && cmd == `FCSD_D_LOCKE
                   && BUS_ADDR[19:8] == 12'h000) begin        // [R16]
                  op_sel = FCSD_OP_LOCKE;
                  launch = 1'b1;
               end else if (cmd3_q == `FCSD_D_LOCKP
                            && cmd == `FCSD_D_LOCKP
                            && !BUS_ADDR[19]) begin           // [R17]
                  if (sel_field <= `FCSD_LOCK_MAX) begin
                     op_sel = FCSD_OP_LOCKP;                  // [R14]
                     launch = 1'b1;
                  end else if (sel_field >= `FCSD_SWAP_BASE
                               && sel_field <= `FCSD_SWAP_MAX) begin
                     op_sel = FCSD_OP_SWAP;                   // [R17]
                     launch = 1'b1;
                  end
               end
               if (launch) st_d = FCSD_BUSY;
            end
         end
         // program: four words to the page target
         FCSD_PROG: begin
            if (is_reset) begin
               st_d = FCSD_READ;                              // [R23]
            end else if (wr_hit) begin
               wcnt_d = wcnt_q + 3'h1;                        // [R8]
               if (wcnt_q == 3'h0) begin
                  tgt_sel = {BUS_ADDR[18:3], 3'h0};           // [R9]
               end
               if (wcnt_q + 3'h1 == `FCSD_PROG_WORDS) begin
                  op_sel = FCSD_OP_PROG;
                  launch = 1'b1;
                  st_d   = FCSD_BUSY;
               end
            end
         end
         // identification mode until a reset write
         FCSD_ID: begin
            if (is_reset) begin
               st_d  = FCSD_READ;                             // [R22]
               csv_d = 1'b0;
            end else if (wr_hit && cmd == `FCSD_D_IDSEL) begin
               csel_d = BUS_ADDR[15:14];                      // [R19]
               csv_d  = 1'b1;
            end
         end
         default: st_d = FCSD_READ;
      endcase
   end

   // register the sequence walker
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_q   <= FCSD_READ;
         cmd3_q <= 8'h00;
         wcnt_q <= 3'h0;
         csel_q <= 2'h0;
         csv_q  <= 1'b0;
      end else begin
         st_q   <= st_d;
         cmd3_q <= cmd3_d;
         wcnt_q <= wcnt_d;
         csel_q <= csel_d;
         csv_q  <= csv_d;
      end
   end

   // program words go through the burst store; readout trails by one
   logic       pw_wr;
   logic [1:0] pw_idx;
   logic [1:0] pw_last;   // index of the word just stored
   assign pw_wr  = st_q == FCSD_PROG && wr_hit && !is_reset;
   assign pw_idx = wcnt_q[1:0];
   // the count has already stepped past the stored word, so look back one
   assign pw_last = 2'(wcnt_q - 3'h1);
   fcsd_word_store #(.WIDTH(32), .DEPTH(4)) u_store (
      .clk     (CLK),
      .rst_n   (RST_N),
      .wr_en   (pw_wr),
      .wr_idx  (pw_idx),
      .wr_data (BUS_WDATA),                                   // [R9]
      .rd_idx  (pw_last),
      .rd_data (PROGRAM_WORD)                                 // [R9]
   );

   // output registers
   logic        start_d, erase_arr_d, hi_d, pwv_d, pwv_q, cv_d, busy_d;
   logic [3:0]  code_d, swap_d;
   logic [18:0] tgt_d;
   logic [7:0]  lsel_d;
   logic [15:0] cval_d;
   always_comb begin
      start_d     = launch;
      code_d      = launch ? op_sel : OP_CODE;
      erase_arr_d = launch ? (op_sel == FCSD_OP_LOCKE && SECURE)
                           : OP_ERASE_ARRAY;                  // [R24]
      lsel_d      = (launch && op_sel == FCSD_OP_LOCKP) ? sel_field
                                                      : LOCK_BIT_SELECT;
      hi_d        = (launch && op_sel == FCSD_OP_LOCKP)
                    ? (sel_field >= `FCSD_LOCK_BLK16)          // [R15]
                    : LOCK_IN_HIGH_WORD;
      swap_d      = (launch && op_sel == FCSD_OP_SWAP)
                    ? 4'(sel_field - `FCSD_SWAP_BASE) : SWAP_BIT_SELECT;
      tgt_d       = TARGET_ADDR;
      if ((launch && op_sel != FCSD_OP_PROG) || (pw_wr && wcnt_q == 3'h0))
         tgt_d = tgt_sel;
      pwv_d       = pw_wr;
      busy_d      = st_d == FCSD_BUSY;
      // code answers a read in identification mode; reserved gives zero
      cv_d        = BUS_RD && in_region && st_q == FCSD_ID && csv_q; // [R1]
      case (csel_q)
         2'h0:    cval_d = CODE_MFR;                          // [R19]
         2'h1:    cval_d = CODE_DEV;
         2'h3:    cval_d = CODE_MAC;
         default: cval_d = 16'h0000;
      endcase
      if (!cv_d) cval_d = CODE_VALUE;
   end
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         OP_START           <= 1'b0;
         OP_CODE            <= FCSD_OP_NONE;
         OP_ERASE_ARRAY     <= 1'b0;
         TARGET_ADDR        <= '0;
         LOCK_BIT_SELECT    <= 8'h00;
         LOCK_IN_HIGH_WORD  <= 1'b0;
         SWAP_BIT_SELECT    <= 4'h0;
         pwv_q              <= 1'b0;
         PROGRAM_WORD_VALID <= 1'b0;
         CODE_VALID         <= 1'b0;
         CODE_VALUE         <= 16'h0000;
         BUSY               <= 1'b0;
         ID_MODE            <= 1'b0;
      end else begin
         OP_START           <= start_d;
         OP_CODE            <= code_d;
         OP_ERASE_ARRAY     <= erase_arr_d;
         TARGET_ADDR        <= tgt_d;
         LOCK_BIT_SELECT    <= lsel_d;
         LOCK_IN_HIGH_WORD  <= hi_d;
         SWAP_BIT_SELECT    <= swap_d;
         pwv_q              <= pwv_d;
         PROGRAM_WORD_VALID <= pwv_q;
         CODE_VALID         <= cv_d;
         CODE_VALUE         <= cval_d;
         BUSY               <= busy_d;
         ID_MODE            <= st_d == FCSD_ID;
      end
   end
endmodule // fcsd_decoder

/* verilog/fcsd_params.svh */
// constants for the flash command sequence decoder
// assumes a 32-bit bus write/read strobe interface on one clock
// Operation
// (R1) all cycles writes, except identification read
// (R2) one 32-bit write; low byte is command
// (R3) bit 19 selects upper half on large parts
// (R4) address bits 31:20 must equal 0x5e0
// (R5) pattern taken from address bits 15:9
// (R6) three unlock writes: aa, 55, command
// (R7) write f0 with bit19 low resets
// (R8) program a0 then four words ascending
// (R9) program page from address bits 18:3
// (R10) erase 80, aa, 55, then type byte
// (R11) block target from address bits 18:13
// (R12) page target from address bits 18:12
// (R13) issuer uses mirror addresses for erase
// (R14) lock program 9a twice, bits 11:4
// (R15) select 0-7 pages, 8-38 blocks, split words
// (R16) lock erase 6a twice, bits 19:8 zero
// (R17) swap set 9a twice, bit 19 zero
// (R18) id read 90 then 00 to select
// (R19) bits 15:14 pick code; 10 reserved
// (R20) issuer checks oscillator stable before programming
// (R21) ignore sequences while operation runs
// (R22) stay in identification mode until reset
// (R23) reset write cancels partial sequence
// (R24) secure lock erase wipes array first
// (R25) mismatch abandons sequence to read mode
`ifndef FCSD_PARAMS_SVH
`define FCSD_PARAMS_SVH
`define FCSD_REGION      12'h5e0
`define FCSD_PAT_54      7'h2a
`define FCSD_PAT_AA      7'h55
`define FCSD_D_AA        8'haa
`define FCSD_D_55        8'h55
`define FCSD_D_RESET     8'hf0
`define FCSD_D_PROG      8'ha0
`define FCSD_D_ERASE     8'h80
`define FCSD_D_LOCKP     8'h9a
`define FCSD_D_LOCKE     8'h6a
`define FCSD_D_ID        8'h90
`define FCSD_D_IDSEL     8'h00
`define FCSD_D_CHIP      8'h10
`define FCSD_D_AREA      8'h20
`define FCSD_D_BLOCK     8'h30
`define FCSD_D_PAGE      8'h40
`define FCSD_PROG_WORDS  3'h4
`define FCSD_LOCK_MAX    8'h26
`define FCSD_LOCK_BLK16  8'h17
`define FCSD_SWAP_BASE   8'h88
`define FCSD_SWAP_MAX    8'h92
`define FCSD_CODE_RSVD   2'h2
`endif

/* verilog/fcsd_pkg.sv */
// types for the flash command sequence decoder
// assumes fcsd_params.svh holds the numeric constants
package fcsd_pkg;
   // decoder sequence steps
   typedef enum logic [3:0] {
      FCSD_READ, FCSD_U2, FCSD_U3, FCSD_E4, FCSD_E5, FCSD_E6,
      FCSD_LOCK4, FCSD_PROG, FCSD_ID, FCSD_BUSY
   } fcsd_state_t;
   // operation launched toward the flash engine
   typedef enum logic [3:0] {
      FCSD_OP_NONE, FCSD_OP_PROG, FCSD_OP_CHIP, FCSD_OP_AREA,
      FCSD_OP_BLOCK, FCSD_OP_PAGE, FCSD_OP_LOCKP, FCSD_OP_LOCKE,
      FCSD_OP_SWAP
   } fcsd_op_t;
endpackage

/* verilog/fcsd_word_store.sv */
// small register memory holding the program words of one burst
// assumes write and read on the same clock; read data registered
`timescale 1ns/1ps
module fcsd_word_store #(
   parameter int WIDTH = 32,   // word width
   parameter int DEPTH = 4     // words per burst
) (
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   // write side
   input  wire logic                     wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
   input  wire logic [WIDTH-1:0]         wr_data,
   // read side
   input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
   output logic      [WIDTH-1:0]         rd_data
);
   logic [WIDTH-1:0] mem_q [DEPTH];   // storage
   initial begin
      if (DEPTH < 2 || WIDTH < 1) $error("fcsd_word_store: bad size");
   end
   // per-entry storage, one generate loop
   for (genvar i = 0; i < DEPTH; i++) begin : g_ent
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            mem_q[i] <= '0;
         end else if (wr_en && wr_idx == i) begin
            mem_q[i] <= wr_data;
         end
      end
   end
   // registered read port
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem_q[rd_idx];
      end
   end
endmodule // fcsd_word_store

/* testbench/fcsd_decoder_chk.sv */
// port assertions for the flash command sequence decoder
// assumes a bind into fcsd_decoder; one clock, async active-low reset
`timescale 1ns/1ps
module fcsd_decoder_chk #(
   parameter int ADDR_W = 32   // bus address width
) (
   // clock and reset
   input wire logic              CLK,
   input wire logic              RST_N,
   // processor bus cycle
   input wire logic              BUS_WR,
   input wire logic              BUS_RD,
   input wire logic [ADDR_W-1:0] BUS_ADDR,
   input wire logic [31:0]       BUS_WDATA,
   // engine status
   input wire logic              OP_DONE,
   input wire logic              SECURE,
   // decoder outputs
   input wire logic              OP_START,
   input wire logic [3:0]        OP_CODE,
   input wire logic              OP_ERASE_ARRAY,
   input wire logic [7:0]        LOCK_BIT_SELECT,
   input wire logic              LOCK_IN_HIGH_WORD,
   input wire logic              PROGRAM_WORD_VALID,
   input wire logic [31:0]       PROGRAM_WORD,
   input wire logic              CODE_VALID,
   input wire logic              BUSY,
   input wire logic              ID_MODE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   logic in_region;   // cycle aimed at the flash command window
   assign in_region = (BUS_ADDR[31:20] == 12'h5e0);
   // foreign writes must never launch anything
   a_region_only: assert property (BUS_WR && !in_region |=> !OP_START)
      else $error("launch after a write outside the window");
   a_start_cause: assert property (OP_START |-> $past(BUS_WR && in_region))
      else $error("launch without a preceding window write");
   a_start_pulse: assert property (OP_START |=> !OP_START)
      else $error("launch pulse longer than one cycle");
   a_start_busy: assert property (OP_START |-> BUSY)
      else $error("launch without busy");
   // the engine owns the decoder until it reports done
   a_busy_ignore: assert property (BUSY && !OP_DONE |=> !OP_START)
      else $error("launch accepted while busy");
   a_busy_release: assert property (BUSY && OP_DONE && !OP_START |=> !BUSY)
      else $error("busy held after done");
   a_lock_word: assert property (OP_START && OP_CODE == 4'h6 |->
      LOCK_IN_HIGH_WORD == (LOCK_BIT_SELECT >= 8'h17))
      else $error("lock bit placed in wrong status word");
   a_erase_array: assert property (OP_START |->
      OP_ERASE_ARRAY == (OP_CODE == 4'h7 && SECURE))
      else $error("array wipe flag wrong at launch");
   a_word_pass: assert property (PROGRAM_WORD_VALID |->
      $past(BUS_WR, 2) && PROGRAM_WORD == $past(BUS_WDATA, 2))
      else $error("program word not the written word");
   a_code_cause: assert property (CODE_VALID |-> $past(BUS_RD && ID_MODE))
      else $error("code answer without an identification read");
   a_reset_exit: assert property (BUS_WR && in_region && !BUSY &&
      BUS_WDATA[7:0] == 8'hf0 && !BUS_ADDR[19] |=> !ID_MODE)
      else $error("reset write left identification mode");
endmodule // fcsd_decoder_chk
bind fcsd_decoder fcsd_decoder_chk #(.ADDR_W(ADDR_W)) u_chk (
   .CLK(CLK), .RST_N(RST_N), .BUS_WR(BUS_WR), .BUS_RD(BUS_RD),
   .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA), .OP_DONE(OP_DONE),
   .SECURE(SECURE), .OP_START(OP_START), .OP_CODE(OP_CODE),
   .OP_ERASE_ARRAY(OP_ERASE_ARRAY), .LOCK_BIT_SELECT(LOCK_BIT_SELECT),
   .LOCK_IN_HIGH_WORD(LOCK_IN_HIGH_WORD), .PROGRAM_WORD(PROGRAM_WORD),
   .PROGRAM_WORD_VALID(PROGRAM_WORD_VALID), .CODE_VALID(CODE_VALID),
   .BUSY(BUSY), .ID_MODE(ID_MODE));

/* testbench/fcsd_engine_model.sv */
// flash engine stand-in: answers each launch with a done pulse
// assumes launches arrive as one-cycle pulses on clk
`timescale 1ns/1ps
module fcsd_engine_model (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // control
   input  wire logic slow,
   input  wire logic op_start,
   // completion
   output logic      op_done
);
   logic [5:0] cnt_q;    // cycles left in the running operation
   logic [5:0] cnt_d;    // next count
   logic       done_d;   // next done pulse
   // load on launch, count down, pulse done on the last cycle
   always_comb begin
      cnt_d  = cnt_q;
      done_d = 1'h0;
      if (op_start) begin
         // a slow run covers a whole second sequence of writes
         cnt_d = slow ? 6'h28 : 6'h03;
      end else if (cnt_q != 6'h00) begin
         cnt_d  = cnt_q - 6'h01;
         done_d = (cnt_q == 6'h01);
      end
   end
   // registers only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q   <= 6'h00;
         op_done <= 1'h0;
      end else begin
         cnt_q   <= cnt_d;
         op_done <= done_d;
      end
   end
endmodule // fcsd_engine_model

/* testbench/tb_top.sv */
// self-checking bench for the flash command sequence decoder
// assumes the decoder, its bound checker and the engine model
`timescale 1ns/1ps
module tb_top;
   // bus drive, one-cycle strobes launched at rising edges
   logic        CLK = 1'h0;
   logic        RST_N = 1'h0;
   logic        BUS_WR = 1'h0;
   logic        BUS_RD = 1'h0;
   logic [31:0] BUS_ADDR = 32'h0;
   logic [31:0] BUS_WDATA = 32'h0;
   logic        SECURE = 1'h0;
   logic        slow = 1'h0;
   // decoder outputs and engine done
   logic        OP_DONE, OP_START, OP_ERASE_ARRAY, LOCK_IN_HIGH_WORD;
   logic        PROGRAM_WORD_VALID, CODE_VALID, BUSY, ID_MODE;
   logic [3:0]  OP_CODE, SWAP_BIT_SELECT;
   logic [18:0] TARGET_ADDR;
   logic [7:0]  LOCK_BIT_SELECT;
   logic [31:0] PROGRAM_WORD;
   logic [15:0] CODE_VALUE;
   // bookkeeping and captured launch fields
   int          mismatches = 0;
   int          num_checks = 0;
   int          n_start = 0, seen = 0;
   int          n_code = 0;
   int          i, j, s;
   logic [31:0] words[$];
   logic [3:0]  c_code, c_swap;
   logic [18:0] c_tgt;
   logic [7:0]  c_lock;
   logic        c_high, c_arr;
   logic [7:0]  lsel[4] = '{8'h00, 8'h16, 8'h17, 8'h26};
   logic [7:0]  etype[4] = '{8'h10, 8'h20, 8'h30, 8'h40};
   logic [18:0] etgt[4] = '{19'h0, 19'h7b5a4, 19'h7a000, 19'h7b000};
   logic [15:0] codes[4] = '{16'h0011, 16'h0022, 16'h0000, 16'h0033};
   always #5 CLK = ~CLK;
   fcsd_decoder dut (.CLK(CLK), .RST_N(RST_N), .BUS_WR(BUS_WR),
      .BUS_RD(BUS_RD), .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA),
      .OP_DONE(OP_DONE), .SECURE(SECURE), .OP_START(OP_START),
      .OP_CODE(OP_CODE), .OP_ERASE_ARRAY(OP_ERASE_ARRAY),
      .TARGET_ADDR(TARGET_ADDR), .LOCK_BIT_SELECT(LOCK_BIT_SELECT),
      .LOCK_IN_HIGH_WORD(LOCK_IN_HIGH_WORD),
      .SWAP_BIT_SELECT(SWAP_BIT_SELECT), .PROGRAM_WORD(PROGRAM_WORD),
      .PROGRAM_WORD_VALID(PROGRAM_WORD_VALID), .CODE_VALID(CODE_VALID),
      .CODE_VALUE(CODE_VALUE), .BUSY(BUSY), .ID_MODE(ID_MODE));
   fcsd_engine_model u_eng (.clk(CLK), .rst_n(RST_N), .slow(slow),
      .op_start(OP_START), .op_done(OP_DONE));
   // monitor: sample pulses before the edge updates them
   always @(posedge CLK) begin
      if (OP_START === 1'h1) begin
         n_start++;
         c_code = OP_CODE;
         c_tgt  = TARGET_ADDR;
         c_lock = LOCK_BIT_SELECT;
         c_high = LOCK_IN_HIGH_WORD;
         c_swap = SWAP_BIT_SELECT;
         c_arr  = OP_ERASE_ARRAY;
      end
      if (PROGRAM_WORD_VALID === 1'h1) words.push_back(PROGRAM_WORD);
      if (CODE_VALID === 1'h1) n_code++;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
         mismatches++;
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // one word transfer; released lines show the inverse, not old values
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge CLK);
      BUS_WR    <= 1'h1;
      BUS_ADDR  <= a;
      BUS_WDATA <= d;
      @(posedge CLK);
      BUS_WR    <= 1'h0;
      BUS_ADDR  <= ~a;
      BUS_WDATA <= ~d;
   endtask
   task automatic rd(input logic [31:0] a);
      @(posedge CLK);
      BUS_RD   <= 1'h1;
      BUS_ADDR <= a;
      @(posedge CLK);
      BUS_RD   <= 1'h0;
      BUS_ADDR <= ~a;
   endtask
   // three unlock writes, low half of the array, word transfers
   task automatic unlock(input logic [31:0] cmd);
      wr(32'h5e00_5400, 32'haa);
      wr(32'h5e00_aa00, 32'h55);
      wr(32'h5e00_5400, cmd);
   endtask
   task automatic erase_pre();
      unlock(32'h80);
      wr(32'h5e00_5400, 32'haa);
      wr(32'h5e00_aa00, 32'h55);
   endtask
   // wait for a launch, then for the engine to let go
   task automatic wait_start();
      for (int k = 0; k < 40 && n_start == seen; k++) @(posedge CLK);
      if (n_start == seen) begin
         mismatches++;
         report_and_stop();
      end
      seen = n_start;
      for (int k = 0; k < 80 && BUSY !== 1'h0; k++) @(posedge CLK);
      if (BUSY !== 1'h0) begin
         mismatches++;
         report_and_stop();
      end
   endtask
   task automatic no_start();
      repeat (8) @(posedge CLK);
      check(n_start, seen);
   endtask
   // main sequence
   initial begin
      repeat (10) @(posedge CLK);
      RST_N <= 1'h1;
      @(posedge CLK);
      check({OP_START, BUSY, ID_MODE, CODE_VALID}, 32'h0);
      for (i = 0; i < 4; i++) begin
         unlock(32'h9a);
         wr(32'h5e00_0000 | (32'(lsel[i]) << 4), 32'h9a);
         wait_start();
         check(c_code, 4'h6);
         check(c_lock, lsel[i]);
         check(c_high, lsel[i] >= 8'h17);
      end
      unlock(32'h9a);
      wr(32'h5e00_0920, 32'h9a);
      wait_start();
      check(c_code, 4'h8);
      check(c_swap, 4'ha);
      for (i = 0; i < 2; i++) begin
         SECURE <= i[0];
         unlock(32'h6a);
         wr(32'h5e00_0000, 32'h6a);
         wait_start();
         check(c_code, 4'h7);
         check(c_arr, i[0]);
      end
      for (i = 0; i < 4; i++) begin
         erase_pre();
         wr(32'h5e07_b5a4, 32'(etype[i]));
         wait_start();
         check(c_code, 4'(i + 2));
         if (i > 0) check(c_tgt, etgt[i]);
      end
      erase_pre();
      wr(32'h5e07_b5a4, 32'h50);
      no_start();
      unlock(32'ha0);
      for (i = 0; i < 4; i++) wr(32'h5e01_2348 + 32'(4 * i), 32'hc0de_0000 + i);
      wait_start();
      check(c_code, 4'h1);
      check(c_tgt, 19'h12348);
      check(words.size(), 32'h4);
      for (i = 0; i < 4; i++) check(words[i], 32'hc0de_0000 + i);
      wr(32'h5e00_5400, 32'haa);
      wr(32'h5e00_aa00, 32'h54);
      wr(32'h5e00_5400, 32'h9a);
      wr(32'h5e00_0160, 32'h9a);
      no_start();
      unlock(32'h9a);
      wr(32'h5e10_0160, 32'h9a);
      wr(32'h5e00_0000, 32'hf0);
      wr(32'h5e00_0160, 32'h9a);
      no_start();
      s = seen;
      slow <= 1'h1;
      unlock(32'h6a);
      wr(32'h5e00_0000, 32'h6a);
      unlock(32'h9a);
      wr(32'h5e00_0160, 32'h9a);
      wait_start();
      check(n_start, s + 1);
      slow <= 1'h0;
      unlock(32'h90);
      @(posedge CLK);
      check(ID_MODE, 1'h1);
      for (i = 0; i < 4; i++) begin
         wr(32'h5e00_0000 | (32'(i) << 14), 32'h0);
         s = n_code;
         rd(32'h5e00_1234);
         for (j = 0; j < 10 && n_code == s; j++) @(posedge CLK);
         check(n_code, s + 1);
         check(CODE_VALUE, codes[i]);
      end
      wr(32'h5e00_0000, 32'hf0);
      @(posedge CLK);
      check(ID_MODE, 1'h0);
      report_and_stop();
   end
endmodule // tb_top
